// ===== include/bcp_consts.svh
// constants for the buffered compare pwm channels
//
// Operation
// R1: link bit of channel 0 merges channels 0 and 1 onto the channel 0 pin.
// R2: right after linking, channel 0 value registers govern the merged output.
// R3: a write to the partner value takes control only from the next overflow.
// R4: at each linked overflow the most recently written value set becomes active.
// R5: while 0/1 linked, channel 1 control is ignored and its pin released.
// R6: link bit of channel 2 merges 2 and 3 on channel 2 pin, same switching.
// R7: while 2/3 linked, channel 3 control is ignored and its pin released.
// R8: software must not write the currently active value set in buffered mode.
// R9: with toggle-on-overflow set, the pin toggles at every counter overflow; the code lets a same-tick compare or the max-duty bit win.
// R10: pulse width is the time from overflow to the channel compare match.
// R11: software picks clear on compare for high pulses, set for low pulses.
// R12: modulo 255 on undivided clock gives a period of 256 clocks.
// R13: an 8-bit period with value 128 gives 50% duty, 256 width steps.
// R14: compare only on equality; a passed value gives no compare this period.
// R15: compare event at end of pulse, overflow event at end of period.
// R16: software shortens unbuffered width inside the compare event handler.
// R17: software lengthens unbuffered width inside the overflow event handler.
// R18: software raising a plain compare value writes in the overflow handler.
// R19: software never selects toggle as the compare action when doing pwm.
// R20: in buffered pwm a partner write sets width from the next period on.
// R21: overflow happens when the counter rolls to zero after the modulo match.
// R22: mode field encodes unbuffered as 0:1 and buffered as 1:0.
// R23: the pair-link bit takes priority over the unbuffered mode bit.
// R24: toggle-on-overflow cleared gives 0% duty; max-duty bit then gives 100%.
// R25: each tick compares counter to the active value and applies the pin action.
`ifndef BCP_CONSTS_SVH
`define BCP_CONSTS_SVH

`define BCP_CNT_W        16
`define BCP_MODE_A_POS   0
`define BCP_MODE_B_POS   1
`define BCP_MODE_UNBUF   2'h1
`define BCP_MODE_BUF     2'h2
`define BCP_ACT_NONE     2'h0
`define BCP_ACT_TOGGLE   2'h1
`define BCP_ACT_CLEAR    2'h2
`define BCP_ACT_SET      2'h3
`define BCP_PIN_RST      1'h0
`define BCP_VAL_RST      16'h0000

`endif

// ===== include/bcp_pkg.sv
// types shared by the buffered compare pwm channels
package bcp_pkg;
  typedef enum logic [1:0] {
    BCP_SRC_EVEN = 2'h1,
    BCP_SRC_ODD  = 2'h2
  } bcp_src_e;
  typedef logic [1:0] bcp_act_t;
endpackage

// ===== hdl/bcp_chan.sv
// one output compare channel: compare, overflow toggle, max duty
`timescale 1ns/1ns
`default_nettype none
`include "bcp_consts.svh"
module bcp_chan #(
  parameter int CNT_W = `BCP_CNT_W
) (
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic              en_i,
  input  wire logic              tick_i,
  input  wire logic              ovf_i,
  input  wire logic [CNT_W-1:0]  cnt_i,
  input  wire logic [CNT_W-1:0]  cmp_val_i,
  input  wire bcp_pkg::bcp_act_t act_i,
  input  wire logic              tov_i,
  input  wire logic              max_i,
  output logic                   pin_o,
  output logic                   cmp_evt_o
);
  import bcp_pkg::*;

  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("bcp_chan: CNT_W must be 2 to 32");
    end
  endgenerate

  logic match;
  logic pulse_lvl;

  // equality only, so a value already passed waits for the next period
  assign match     = tick_i && (cnt_i == cmp_val_i); // R14 R13 R25
  assign pulse_lvl = (act_i == `BCP_ACT_SET) ? 1'h0 : 1'h1;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_o <= `BCP_PIN_RST;
    end else if (en_i) begin
      if (max_i && tick_i && ovf_i) begin
        pin_o <= pulse_lvl; // R24
      end else if (match && !max_i) begin
        // compare wins over the overflow toggle in the same tick
        case (act_i)
          `BCP_ACT_TOGGLE: pin_o <= ~pin_o;
          `BCP_ACT_CLEAR:  pin_o <= 1'h0; // R10
          `BCP_ACT_SET:    pin_o <= 1'h1; // R10
          default:         pin_o <= pin_o;
        endcase
      end else if (tick_i && ovf_i && tov_i) begin
        pin_o <= ~pin_o; // R9 R12
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_evt_o <= 1'h0;
    end else begin
      cmp_evt_o <= en_i && match; // R15
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  a_tov_toggles: assert property (en_i && tick_i && ovf_i && tov_i && !max_i && !match
    |=> pin_o != $past(pin_o)) else $error("pin did not toggle on overflow"); // R9
  a_no_tov_hold: assert property (en_i && tick_i && ovf_i && !tov_i && !max_i && !match
    |=> $stable(pin_o)) else $error("pin moved on overflow without toggle"); // R24
  a_cmp_set_pin: assert property (en_i && match && !max_i && act_i == `BCP_ACT_SET
    |=> pin_o) else $error("set action did not raise pin"); // R25
  a_cmp_evt_match: assert property (cmp_evt_o |-> $past(en_i && tick_i)
    && $past(cnt_i) == $past(cmp_val_i)) else $error("compare event without match"); // R14
  a_max_level: assert property (en_i && max_i && tick_i && ovf_i
    |=> pin_o == $past(pulse_lvl)) else $error("max duty level wrong"); // R24
  c_cmp_clear: cover property (en_i && match && act_i == `BCP_ACT_CLEAR);
endmodule
`default_nettype wire

// ===== hdl/bcp_top.sv
// four compare/pwm channels with pair-linked buffered value registers
`timescale 1ns/1ns
`default_nettype none
`include "bcp_consts.svh"
module bcp_top #(
  parameter int CNT_W = `BCP_CNT_W
) (
  input  wire logic                clock_i,
  input  wire logic                nrst_i,
  // counter side, same clock: tick enable, new count value, wrap pulse
  input  wire logic                tick_i,
  input  wire logic [CNT_W-1:0]    cnt_i,
  input  wire logic                ovf_i,
  // per channel control, two bits each: mode b:a, action, plus single bits
  input  wire logic [7:0]          chan_mode_i,
  input  wire logic [7:0]          chan_act_i,
  input  wire logic [3:0]          tov_i,
  input  wire logic [3:0]          max_i,
  // value register writes
  input  wire logic [3:0]          val_wr_i,
  input  wire logic [CNT_W-1:0]    val_data_i,
  // pins and events
  output logic [3:0]               chan_pin_o,
  output logic [3:0]               chan_pin_oe_n_o,
  output logic [3:0]               cmp_evt_o,
  output logic                     ovf_evt_o,
  output var bcp_pkg::bcp_src_e    pair01_src_o,
  output var bcp_pkg::bcp_src_e    pair23_src_o,
  output logic [4*CNT_W-1:0]       chan_value_o
);
  import bcp_pkg::*;

  generate
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("bcp_top: CNT_W must be 2 to 32");
    end
  endgenerate

  logic [CNT_W-1:0] val_r [4];
  logic [1:0]       link;
  logic [1:0]       link_q;
  bcp_src_e         sel_r  [2];
  bcp_src_e         last_r [2];
  logic [3:0]       chan_en;
  logic [CNT_W-1:0] cmp_val [4];
  logic             ovf_tick;

  assign ovf_tick = tick_i && ovf_i; // R21

  // value registers, one write port each
  genvar v;
  generate
    for (v = 0; v < 4; v++) begin : g_val
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          val_r[v] <= CNT_W'(`BCP_VAL_RST);
        end else if (val_wr_i[v]) begin
          val_r[v] <= val_data_i;
        end
      end
      assign chan_value_o[v*CNT_W +: CNT_W] = val_r[v];
    end
  endgenerate

  // pair link state and source selection
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      localparam int E = 2 * p;
      localparam int O = 2 * p + 1;

      // link bit wins over the unbuffered bit of the same field
      assign link[p] = chan_mode_i[2*E + `BCP_MODE_B_POS]; // R1 R6 R23 R22

      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          link_q[p] <= 1'h0;
        end else begin
          link_q[p] <= link[p];
        end
      end

      // which value set software touched last while linked
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          last_r[p] <= BCP_SRC_EVEN;
        end else if (!(link[p] && link_q[p])) begin
          last_r[p] <= BCP_SRC_EVEN; // R2
        end else if (val_wr_i[O]) begin
          last_r[p] <= BCP_SRC_ODD; // R3 R20
        end else if (val_wr_i[E]) begin
          last_r[p] <= BCP_SRC_EVEN; // R4
        end
      end

      // a write landing on the overflow tick itself waits one more period
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sel_r[p] <= BCP_SRC_EVEN;
        end else if (!(link[p] && link_q[p])) begin
          sel_r[p] <= BCP_SRC_EVEN; // R2
        end else if (ovf_tick) begin
          sel_r[p] <= last_r[p]; // R4 R3 R20
        end
      end

      always_comb begin
        if (link[p] && sel_r[p] == BCP_SRC_ODD) begin
          cmp_val[E] = val_r[O]; // R4
        end else begin
          cmp_val[E] = val_r[E]; // R2
        end
        cmp_val[O] = val_r[O];
      end

      // partner channel is dead while linked, whatever its own control says
      always_comb begin
        chan_en[E] = (link[p] || chan_mode_i[2*E +: 2] == `BCP_MODE_UNBUF)
                     && chan_act_i[2*E +: 2] != `BCP_ACT_NONE; // R23
        chan_en[O] = !link[p] && chan_mode_i[2*O +: 2] == `BCP_MODE_UNBUF
                     && chan_act_i[2*O +: 2] != `BCP_ACT_NONE; // R5 R7
      end
    end
  endgenerate

  assign pair01_src_o = sel_r[0];
  assign pair23_src_o = sel_r[1];

  // released pins float to the port logic
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chan_pin_oe_n_o <= 4'hf;
    end else begin
      chan_pin_oe_n_o <= ~chan_en; // R5 R7
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_evt_o <= 1'h0;
    end else begin
      ovf_evt_o <= ovf_tick; // R15 R21
    end
  end

  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chan
      bcp_chan #(
        .CNT_W (CNT_W)
      ) u_chan (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .en_i      (chan_en[c]),
        .tick_i    (tick_i),
        .ovf_i     (ovf_i),
        .cnt_i     (cnt_i),
        .cmp_val_i (cmp_val[c]),
        .act_i     (chan_act_i[2*c +: 2]),
        .tov_i     (tov_i[c]),
        .max_i     (max_i[c]),
        .pin_o     (chan_pin_o[c]),
        .cmp_evt_o (cmp_evt_o[c])
      );
    end
  endgenerate

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  generate
    for (p = 0; p < 2; p++) begin : g_chk
      a_link_src_init: assert property ($rose(link[p]) |=> sel_r[p] == BCP_SRC_EVEN)
        else $error("new link did not start on even set"); // R2
      a_ovf_src_switch: assert property (link[p] && link_q[p] && ovf_tick
        |=> sel_r[p] == $past(last_r[p])) else $error("overflow did not take last set"); // R4
      a_src_hold: assert property (link[p] && link_q[p] && !ovf_tick
        |=> $stable(sel_r[p])) else $error("source moved between overflows"); // R3
      a_partner_write: assert property (link[p] && link_q[p] && val_wr_i[2*p+1]
        |=> last_r[p] == BCP_SRC_ODD) else $error("partner write not recorded"); // R20
      a_partner_release: assert property (link[p]
        |=> chan_pin_oe_n_o[2*p+1]) else $error("partner pin still driven"); // R5 R7
      a_link_drive: assert property (link[p] && chan_act_i[4*p +: 2] != `BCP_ACT_NONE
        |=> !chan_pin_oe_n_o[2*p]) else $error("linked pin not driven"); // R1 R6
    end
  endgenerate

  a_ovf_event: assert property (ovf_tick |=> ovf_evt_o ##1 !ovf_evt_o || $past(ovf_tick, 1))
    else $error("overflow event missing"); // R15
  a_evt_no_spurious: assert property (!ovf_tick |=> !ovf_evt_o)
    else $error("overflow event without overflow"); // R21

  c_switch_odd: cover property (link[0] && ovf_tick && last_r[0] == BCP_SRC_ODD);
  c_switch_back: cover property (sel_r[1] == BCP_SRC_ODD ##[1:600] sel_r[1] == BCP_SRC_EVEN);
  c_cmp_evt: cover property (cmp_evt_o[0] ##[1:600] ovf_evt_o);
endmodule
`default_nettype wire

// ===== verification/bcp_tb.sv
// self-checking bench for the buffered compare pwm channels
`timescale 1ns/1ns
`default_nettype none
`include "bcp_consts.svh"
module tb;
  import bcp_pkg::*;
  logic        clock_i     = 1'b0;
  logic        nrst_i      = 1'b0;
  logic        tick_i      = 1'b0;
  logic [15:0] cnt_i       = 16'h0000;
  logic        ovf_i       = 1'b0;
  logic [7:0]  chan_mode_i = 8'h00;
  logic [7:0]  chan_act_i  = 8'h00;
  logic [3:0]  tov_i       = 4'h0;
  logic [3:0]  max_i       = 4'h0;
  logic [3:0]  val_wr_i    = 4'h0;
  logic [15:0] val_data_i  = 16'h0000;
  logic [3:0]  chan_pin_o;
  logic [3:0]  chan_pin_oe_n_o;
  logic [3:0]  cmp_evt_o;
  logic        ovf_evt_o;
  bcp_src_e    pair01_src_o;
  bcp_src_e    pair23_src_o;
  logic [63:0] chan_value_o;
  logic [15:0] cnt         = 16'h00ff;
  int          bad_count   = 0;
  int          num_checks  = 0;
  logic [31:0] hi;
  logic [31:0] ce;
  logic [31:0] oe;

  bcp_top i_bcp_top (
    .clock_i(clock_i), .nrst_i(nrst_i), .tick_i(tick_i), .cnt_i(cnt_i), .ovf_i(ovf_i),
    .chan_mode_i(chan_mode_i), .chan_act_i(chan_act_i), .tov_i(tov_i), .max_i(max_i),
    .val_wr_i(val_wr_i), .val_data_i(val_data_i), .chan_pin_o(chan_pin_o),
    .chan_pin_oe_n_o(chan_pin_oe_n_o), .cmp_evt_o(cmp_evt_o), .ovf_evt_o(ovf_evt_o),
    .pair01_src_o(pair01_src_o), .pair23_src_o(pair23_src_o), .chan_value_o(chan_value_o)
  );

  always #2 clock_i = ~clock_i;

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got);
      bad_count++;
    end
  endtask

  task automatic wr(input int c, input logic [15:0] v);
    @(negedge clock_i);
    val_wr_i[c] = 1'b1;
    val_data_i = v;
    @(negedge clock_i);
    val_wr_i = 4'h0;
    chk("value", v, chan_value_o[c*16 +: 16]);
  endtask

  // modulo 255 counter; samples one channel while ticking, optional write at a count
  task automatic run(input int n, input int c, input int wa, input int wc,
                     input logic [15:0] wv);
    logic [15:0] nx;
    hi = 0;
    ce = 0;
    oe = 0;
    repeat (n) begin
      @(negedge clock_i);
      hi += chan_pin_o[c];
      ce += cmp_evt_o[c];
      oe += ovf_evt_o;
      nx = (cnt == 16'h00ff) ? 16'h0000 : cnt + 16'h0001;
      cnt = nx;
      tick_i = 1'b1;
      cnt_i = nx;
      ovf_i = (nx == 16'h0000);
      val_wr_i = (nx == wa) ? (4'h1 << wc) : 4'h0;
      if (nx == wa) begin
        val_data_i = wv;
      end
    end
    // idle ticks off, else a held count would match again
    @(negedge clock_i);
    tick_i = 1'b0;
    val_wr_i = 4'h0;
  endtask

  task automatic t_reset;
    chk("oe_n", 4'hf, chan_pin_oe_n_o);
    chk("pins", 4'h0, chan_pin_o);
    chk("src01", BCP_SRC_EVEN, pair01_src_o);
    chk("src23", BCP_SRC_EVEN, pair23_src_o);
    chk("events", 5'h00, {cmp_evt_o, ovf_evt_o});
    chk("values lo", 32'h0, chan_value_o[31:0]);
    chk("values hi", 32'h0, chan_value_o[63:32]);
    $display("test reset done");
  endtask

  task automatic t_unbuf(input logic [1:0] act, input logic [15:0] v, input int exp_hi);
    chan_mode_i = {4'h0, `BCP_MODE_UNBUF, 2'h0};
    chan_act_i[3:2] = act;
    tov_i = 4'h2;
    max_i = 4'h0;
    wr(1, v);
    run(256, 1, -1, 0, 16'h0000);
    run(256, 1, -1, 0, 16'h0000);
    chk("pulse", exp_hi, hi);
    chk("cmp events", 1, ce);
    chk("ovf events", 1, oe);
    chk("drive", 1'b0, chan_pin_oe_n_o[1]);
    $display("test unbuffered done");
  endtask

  task automatic t_duty;
    tov_i = 4'h0;
    run(256, 1, -1, 0, 16'h0000);
    run(256, 1, -1, 0, 16'h0000);
    chk("zero duty", 0, hi);
    max_i = 4'h2;
    run(256, 1, -1, 0, 16'h0000);
    run(256, 1, -1, 0, 16'h0000);
    chk("full duty", 256, hi);
    max_i = 4'h0;
    tov_i = 4'h2;
    $display("test duty limits done");
  endtask

  task automatic t_passed;
    run(256, 1, -1, 0, 16'h0000);
    run(256, 1, 50, 1, 16'h0028);
    chk("passed cmp", 0, ce);
    chk("passed hi", 255, hi);
    run(256, 1, -1, 0, 16'h0000);
    chk("miss cmp", 1, ce);
    run(256, 1, -1, 0, 16'h0000);
    chk("recovered", 40, hi);
    run(256, 1, 100, 1, 16'h0020);
    chk("short late", 40, hi);
    run(256, 1, -1, 0, 16'h0000);
    chk("short next", 32, hi);
    chk("short cmp", 1, ce);
    run(256, 1, 1, 1, 16'h00c0);
    chk("long now", 192, hi);
    chk("long cmp", 1, ce);
    $display("test passed value done");
  endtask

  // plain output compare with toggle action and no overflow toggle
  task automatic t_toggle;
    tov_i = 4'h0;
    chan_act_i[3:2] = `BCP_ACT_TOGGLE;
    wr(1, 16'h0010);
    run(256, 1, -1, 0, 16'h0000);
    run(256, 1, -1, 0, 16'h0000);
    chk("toggle hi", 17, hi);
    chk("toggle cmp", 1, ce);
    $display("test compare toggle done");
  endtask

  task automatic t_buf(input int b);
    logic [1:0] src;
    chan_mode_i = 8'h00;
    // dead partner controls hold toggle; it must never reach a pin
    chan_act_i = {`BCP_ACT_TOGGLE, `BCP_ACT_CLEAR, `BCP_ACT_TOGGLE, `BCP_ACT_CLEAR};
    tov_i = 4'h3 << b;
    wr(b + 1, 16'h00c0);
    wr(b, 16'h0040);
    // pair 0/1 gets both mode bits, so the link bit must win; pair 2/3 gets link only
    chan_mode_i = (b == 0) ? {4'h0, `BCP_MODE_UNBUF, `BCP_MODE_BUF | `BCP_MODE_UNBUF}
                           : {`BCP_MODE_UNBUF, `BCP_MODE_BUF, 4'h0};
    repeat (2) @(negedge clock_i);
    src = (b == 0) ? pair01_src_o : pair23_src_o;
    chk("src linked", BCP_SRC_EVEN, src);
    chk("odd released", 1'b1, chan_pin_oe_n_o[b+1]);
    chk("even drives", 1'b0, chan_pin_oe_n_o[b]);
    run(256, b, -1, 0, 16'h0000);
    run(256, b, 10, b + 1, 16'h00c8);
    chk("even width", 64, hi);
    run(256, b, 10, b, 16'h0020);
    chk("odd width", 200, hi);
    chk("cmp on even", 1, ce);
    src = (b == 0) ? pair01_src_o : pair23_src_o;
    chk("src odd", BCP_SRC_ODD, src);
    run(256, b, -1, 0, 16'h0000);
    chk("back to even", 32, hi);
    chk("odd still free", 1'b1, chan_pin_oe_n_o[b+1]);
    chan_mode_i = 8'h00;
    $display("test buffered pair %0d done", b);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    nrst_i = 1'b1;
    t_reset;
    t_unbuf(`BCP_ACT_SET, 16'h0040, 192);
    t_unbuf(`BCP_ACT_CLEAR, 16'h0080, 128);
    t_duty;
    t_passed;
    t_toggle;
    t_buf(0);
    t_buf(2);
    // second reset in mid-run must clear the values and the pair state again
    nrst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    nrst_i = 1'b1;
    t_reset;
    final_report;
  end
endmodule
`default_nettype wire
